// ==== design/rtc_intc_defs.svh ====
// Register offsets, field positions and reset values of the RTC interrupt map
`ifndef RTC_INTC_DEFS_SVH
`define RTC_INTC_DEFS_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define RTC_IDX_MAIN_STATUS     4'h0
`define RTC_IDX_REAL_TIME_MODE  4'h1
`define RTC_IDX_OUTPUT_MODE     4'h2
`define RTC_IDX_PERIODIC        4'h3
`define RTC_IDX_TIME_SAVE       4'h4
`define RTC_IDX_ALARM_PF_EN     4'h4
`define RTC_IDX_IRQ_STATUS      4'h8
`define RTC_IDX_IRQ_CLEAR       4'h9
`define RTC_IDX_IRQ_ENABLE      4'hA

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTC_MSR_SUMMARY   0
`define RTC_MSR_POWER_FAIL_INPUT     1
`define RTC_MSR_PERIODIC  2
`define RTC_MSR_ALARM     3
`define RTC_MSR_BANK      6
`define RTC_PFR_OSC_FAIL  6
`define RTC_PFR_TEST      7
`define RTC_RTM_RUN       3
`define RTC_RTM_BACKUP_EN 4
`define RTC_OMR_MFO_OSC   7
`define RTC_TSC_ENABLE    7
`define RTC_TSC_NA        6
`define RTC_APIE_ALARM    6
`define RTC_APIE_POWER_FAIL_INPUT    7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTC_RST_BYTE      8'h00
`define RTC_RST_OSC_FAIL  1'b1
`define RTC_RST_SINGLE    1'b1
`define RTC_RST_IRQ       4'h0

`endif

// ==== design/rtc_intc_pkg.sv ====
// Types shared by the RTC interrupt and control map
package rtc_intc_pkg;

  typedef enum logic [10:0] {
    RTC_R_NONE = 11'h001,
    RTC_R_MSR  = 11'h002,
    RTC_R_RTM  = 11'h004,
    RTC_R_OMR  = 11'h008,
    RTC_R_PFR  = 11'h010,
    RTC_R_PIE  = 11'h020,
    RTC_R_TSC  = 11'h040,
    RTC_R_APIE = 11'h080,
    RTC_R_IST  = 11'h100,
    RTC_R_ICL  = 11'h200,
    RTC_R_IEN  = 11'h400
  } rtc_reg_e;

  typedef enum logic [1:0] {
    RTC_OKAY   = 2'h0,
    RTC_SLVERR = 2'h2
  } rtc_resp_e;

endpackage : rtc_intc_pkg

// ==== design/rtc_cmp_if.sv ====
// Carrier between the register map and the alarm comparator
`timescale 1ns/1ps
interface rtc_cmp_if;
  logic [5:0] enable;
  logic [5:0] equal;
  logic       update;
  logic       match;
  modport map (output enable, output equal, output update, input match);
  modport cmp (input enable, input equal, input update, output match);
endinterface : rtc_cmp_if

// ==== design/rtc_alarm_cmp.sv ====
// Alarm comparator: combines six counter equalities into one match pulse
`timescale 1ns/1ps
module rtc_alarm_cmp (
  input wire logic clk,
  input wire logic rst,
  rtc_cmp_if.cmp   cmp
);
  logic [5:0] hit;
  logic       any_en;

  // Disabled comparator sits in the always-equal state
  assign hit    = cmp.equal | ~cmp.enable;
  assign any_en = |cmp.enable;

  // All-zero enables suppress the alarm so software can block it fully
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmp.match <= 1'b0;
    else
      cmp.match <= cmp.update & any_en & (&hit);
  end
endmodule : rtc_alarm_cmp

// ==== design/rtc_intc_top.sv ====
// RTC interrupt enables, status and banked control registers on AXI4-Lite
`timescale 1ns/1ps
`include "rtc_intc_defs.svh"
module rtc_intc_top #(
  parameter int ADDR_W = 6
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        power_fail_input_n,
  input  wire logic        standby_pin,
  input  wire logic        osc_clock_pin,
  input  wire logic [5:0]  rollover_event,
  input  wire logic [5:0]  counter_equal,
  input  wire logic        compare_update,
  input  wire logic        osc_fail_event,
  output logic             interrupt_output_pin_n,
  output logic             multi_function_output,
  output logic             irq,
  output logic [5:0]       compare_enable,
  output logic [1:0]       leap_count,
  output logic             hour_mode_12,
  output logic             clock_run,
  output logic             single_supply,
  output logic             time_save_enable,
  output logic             test_mode
);

  if (ADDR_W < 6) begin : g_chk
    $error("ADDR_W must be at least 6");
  end

  function automatic rtc_intc_pkg::rtc_reg_e rtc_decode(input logic [3:0] idx,
                                                         input logic       bank);
    rtc_intc_pkg::rtc_reg_e r;
    r = rtc_intc_pkg::RTC_R_NONE;
    case (idx)
      `RTC_IDX_MAIN_STATUS:    r = rtc_intc_pkg::RTC_R_MSR;
      `RTC_IDX_REAL_TIME_MODE: r = bank ? rtc_intc_pkg::RTC_R_RTM : rtc_intc_pkg::RTC_R_NONE;
      `RTC_IDX_OUTPUT_MODE:    r = bank ? rtc_intc_pkg::RTC_R_OMR : rtc_intc_pkg::RTC_R_NONE;
      `RTC_IDX_PERIODIC:       r = bank ? rtc_intc_pkg::RTC_R_PIE : rtc_intc_pkg::RTC_R_PFR;
      `RTC_IDX_TIME_SAVE:      r = bank ? rtc_intc_pkg::RTC_R_APIE : rtc_intc_pkg::RTC_R_TSC;
      `RTC_IDX_IRQ_STATUS:     r = rtc_intc_pkg::RTC_R_IST;
      `RTC_IDX_IRQ_CLEAR:      r = rtc_intc_pkg::RTC_R_ICL;
      `RTC_IDX_IRQ_ENABLE:     r = rtc_intc_pkg::RTC_R_IEN;
      default:                 r = rtc_intc_pkg::RTC_R_NONE;
    endcase
    return r;
  endfunction : rtc_decode

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0] aw_idx_r;
  logic       aw_have_r;
  logic [7:0] wdata_r;
  logic       wlane_r;
  logic       w_have_r;
  logic       wr_fire;
  logic       rd_done;
  logic       rd_pfr_r;
  rtc_intc_pkg::rtc_reg_e wr_reg;
  rtc_intc_pkg::rtc_reg_e rd_reg;
  logic [7:0] rd_byte;
  logic       pf_s1_r, pf_s2_r, pf_d_r;
  logic       sb_s1_r, sb_s2_r;
  logic       osc_s1_r, osc_s2_r;
  logic [2:0] msr_ram_r;
  logic       bank_r;
  logic       alarm_st_r;
  logic       per_st_r;
  logic [5:0] pflags_r;
  logic       osc_fail_r;
  logic       single_r;
  logic       test_r;
  logic [7:0] rtm_r, omr_r, tsc_r, pie_r, apie_r;
  logic [3:0] ist_r, ien_r;
  logic       summary_r;
  logic       pf_level, pf_onset, per_evt, standby_drop, interrupt_output_pin_pend, mfo_pend;
  logic       wr_lane;

  rtc_cmp_if cmp_if ();

  assign cmp_if.enable = apie_r[5:0];
  assign cmp_if.equal  = counter_equal;
  assign cmp_if.update = compare_update;

  rtc_alarm_cmp u_cmp (
    .clk (clk),
    .rst (rst),
    .cmp (cmp_if.cmp)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) begin
      {pf_s1_r, pf_s2_r, pf_d_r} <= 3'h7;
      {sb_s1_r, sb_s2_r}         <= 2'h0;
      {osc_s1_r, osc_s2_r}       <= 2'h0;
    end
    else begin
      pf_s1_r  <= power_fail_input_n;
      pf_s2_r  <= pf_s1_r;
      pf_d_r   <= pf_s2_r;
      sb_s1_r  <= standby_pin;
      sb_s2_r  <= sb_s1_r;
      osc_s1_r <= osc_clock_pin;
      osc_s2_r <= osc_s1_r;
    end
  end

  assign pf_level     = ~pf_s2_r;
  assign pf_onset     = pf_d_r & ~pf_s2_r;
  assign per_evt      = |(rollover_event & pie_r[5:0]);
  // Standby in battery-backed mode without backup enable drops interrupt enables
  assign standby_drop = sb_s2_r & ~single_r & ~rtm_r[`RTC_RTM_BACKUP_EN];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_reg  = rtc_decode(aw_idx_r, bank_r);
  assign wr_lane = wr_fire & wlane_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_idx_r      <= 4'h0;
      wdata_r       <= 8'h00;
      wlane_r       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= rtc_intc_pkg::RTC_OKAY;
    end
    else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r     <= 1'b1;
        aw_idx_r      <= s_axi_awaddr[5:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r     <= 1'b1;
        wdata_r      <= s_axi_wdata[7:0];
        wlane_r      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_reg == rtc_intc_pkg::RTC_R_NONE) ?
                        rtc_intc_pkg::RTC_SLVERR : rtc_intc_pkg::RTC_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_have_r     <= 1'b0;
        w_have_r      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign rd_reg  = rtc_decode(s_axi_araddr[5:2], bank_r);
  assign rd_done = s_axi_rvalid & s_axi_rready & rd_pfr_r;

  always_comb
  begin
    case (rd_reg)
      rtc_intc_pkg::RTC_R_MSR:  rd_byte = {msr_ram_r[2], bank_r, msr_ram_r[1:0], alarm_st_r,
                                           per_st_r, pf_level, summary_r};
      rtc_intc_pkg::RTC_R_RTM:  rd_byte = rtm_r;
      rtc_intc_pkg::RTC_R_OMR:  rd_byte = omr_r;
      rtc_intc_pkg::RTC_R_PFR:  rd_byte = {test_r, osc_fail_r, pflags_r};
      rtc_intc_pkg::RTC_R_PIE:  rd_byte = pie_r;
      rtc_intc_pkg::RTC_R_TSC:  rd_byte = tsc_r;
      rtc_intc_pkg::RTC_R_APIE: rd_byte = apie_r;
      rtc_intc_pkg::RTC_R_IST:  rd_byte = {4'h0, ist_r};
      rtc_intc_pkg::RTC_R_IEN:  rd_byte = {4'h0, ien_r};
      default:                  rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= rtc_intc_pkg::RTC_OKAY;
      rd_pfr_r      <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= (rd_reg == rtc_intc_pkg::RTC_R_NONE) ?
                       rtc_intc_pkg::RTC_SLVERR : rtc_intc_pkg::RTC_OKAY;
      rd_pfr_r      <= (rd_reg == rtc_intc_pkg::RTC_R_PFR);
    end
    else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      rd_pfr_r      <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Main status register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) begin
      msr_ram_r <= 3'h0;
      bank_r    <= 1'b0;
    end
    else if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_MSR) begin
      msr_ram_r <= {wdata_r[7], wdata_r[5:4]};
      bank_r    <= wdata_r[`RTC_MSR_BANK];
    end
  end

  // Set beats a same-cycle write-one clear so no event is lost
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) begin
      alarm_st_r <= 1'b0;
      per_st_r   <= 1'b0;
    end
    else begin
      if (cmp_if.match)
        alarm_st_r <= 1'b1;
      else if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_MSR && wdata_r[`RTC_MSR_ALARM])
        alarm_st_r <= 1'b0;
      if (per_evt)
        per_st_r <= 1'b1;
      else if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_MSR && wdata_r[`RTC_MSR_PERIODIC])
        per_st_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Periodic flags, oscillator fail, supply mode, test mode
  // ----------------------------------------------------------------
  // Rollover flags ignore writes; a new rollover wins over the read clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pflags_r <= 6'h00;
    else
      pflags_r <= rollover_event | (rd_done ? 6'h00 : pflags_r);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) begin
      osc_fail_r <= `RTC_RST_OSC_FAIL;
      single_r   <= `RTC_RST_SINGLE;
      test_r     <= 1'b0;
    end
    else if (osc_fail_event) begin
      osc_fail_r <= 1'b1;
      single_r   <= 1'b1;
    end
    else begin
      if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_RTM && wdata_r[`RTC_RTM_RUN])
        osc_fail_r <= 1'b0;
      // Battery-backed mode only once the oscillator is known good
      if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_PFR) begin
        single_r <= wdata_r[`RTC_PFR_OSC_FAIL] | osc_fail_r;
        test_r   <= wdata_r[`RTC_PFR_TEST];
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode, output and time-save registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) begin
      rtm_r <= `RTC_RST_BYTE;
      omr_r <= `RTC_RST_BYTE;
      tsc_r <= `RTC_RST_BYTE;
    end
    else begin
      if (osc_fail_event)
        rtm_r[`RTC_RTM_RUN] <= 1'b0;
      else if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_RTM)
        rtm_r <= wdata_r;
      if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_OMR)
        omr_r <= wdata_r;
      // Power failure freezes the saved time
      if (pf_onset)
        tsc_r[`RTC_TSC_ENABLE] <= 1'b0;
      else if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_TSC)
        tsc_r <= {wdata_r[7], 1'b0, wdata_r[5:0]};
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) begin
      pie_r  <= `RTC_RST_BYTE;
      apie_r <= `RTC_RST_BYTE;
    end
    else if (standby_drop) begin
      pie_r[5:0]  <= 6'h00;
      apie_r[7:6] <= 2'h0;
    end
    else begin
      if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_PIE)
        pie_r <= wdata_r;
      if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_APIE)
        apie_r <= wdata_r;
    end
  end

  // ----------------------------------------------------------------
  // System interrupt status, clear and enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) begin
      ist_r <= `RTC_RST_IRQ;
      ien_r <= `RTC_RST_IRQ;
    end
    else begin
      ist_r <= {osc_fail_event, pf_onset, per_evt, cmp_if.match} |
               (ist_r & ~((wr_lane && wr_reg == rtc_intc_pkg::RTC_R_ICL) ?
                          wdata_r[3:0] : 4'h0));
      if (wr_lane && wr_reg == rtc_intc_pkg::RTC_R_IEN)
        ien_r <= wdata_r[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  assign interrupt_output_pin_pend = (alarm_st_r & apie_r[`RTC_APIE_ALARM]) | per_st_r |
                     (pf_level & apie_r[`RTC_APIE_POWER_FAIL_INPUT]);
  assign mfo_pend  = pf_level & apie_r[`RTC_APIE_POWER_FAIL_INPUT] & ~omr_r[`RTC_OMR_MFO_OSC];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) begin
      interrupt_output_pin_n <= 1'b1;
      multi_function_output  <= 1'b0;
      summary_r              <= 1'b0;
      irq                    <= 1'b0;
    end
    else begin
      interrupt_output_pin_n <= ~interrupt_output_pin_pend;
      multi_function_output  <= omr_r[`RTC_OMR_MFO_OSC] ? osc_s2_r : mfo_pend;
      summary_r              <= interrupt_output_pin_pend | mfo_pend;
      irq                    <= |(ist_r & ien_r);
    end
  end

  assign compare_enable   = apie_r[5:0];
  assign leap_count       = rtm_r[1:0];
  assign hour_mode_12     = rtm_r[2];
  assign clock_run        = rtm_r[`RTC_RTM_RUN];
  assign single_supply    = single_r;
  assign time_save_enable = tsc_r[`RTC_TSC_ENABLE];
  assign test_mode        = test_r;

endmodule : rtc_intc_top

// ==== testbench/rtc_intc_chk.sv ====
// Port-level assertions for the RTC interrupt and control map
`timescale 1ns/1ps
module rtc_intc_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        osc_fail_event,
  input wire logic [5:0]  compare_enable,
  input wire logic [1:0]  leap_count,
  input wire logic        hour_mode_12,
  input wire logic        clock_run,
  input wire logic        single_supply
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_mode_hold: assert property ($changed({leap_count, hour_mode_12})
    |-> $rose(s_axi_bvalid)) else $error("mode bits changed without a write");
  a_cmp_en_hold: assert property ($changed(compare_enable)
    |-> $rose(s_axi_bvalid)) else $error("compare enables changed without a write");
  a_run_stop: assert property (osc_fail_event |=> !clock_run)
    else $error("clock still running after oscillator failure");
  a_supply_set: assert property ($rose(single_supply)
    |-> $rose(s_axi_bvalid) || $past(osc_fail_event)) else $error("supply mode set unprompted");
endmodule : rtc_intc_chk

bind rtc_intc_top rtc_intc_chk u_chk (
  .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .osc_fail_event, .compare_enable, .leap_count, .hour_mode_12, .clock_run,
  .single_supply
);

// ==== testbench/rtc_host_bfm.sv ====
// Host model: AXI4-Lite master issuing one register access at a time
`timescale 1ns/1ps
module rtc_host_bfm (
  input wire logic        clk,
  output logic [5:0]      s_axi_awaddr,
  output logic            s_axi_awvalid,
  input wire logic        s_axi_awready,
  output logic [31:0]     s_axi_wdata,
  output logic [3:0]      s_axi_wstrb,
  output logic            s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  output logic            s_axi_bready,
  output logic [5:0]      s_axi_araddr,
  output logic            s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  output logic            s_axi_rready
);
  // Ready hold-back, so the slave must keep its answer
  int stall = 0;

  initial
  begin
    s_axi_awaddr = 6'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 6'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_p;
    logic w_p;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p || w_p)
    begin
      @(posedge clk);
      if (aw_p && s_axi_awready)
      begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w_p && s_axi_wready)
      begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~{24'h000000, d};
      end
    end
    repeat (stall) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (stall) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : rtc_host_bfm

// ==== testbench/tb_top.sv ====
// Self-checking testbench for the RTC interrupt and control map
`timescale 1ns/1ps
`include "rtc_intc_defs.svh"
`define CHK(n, e, a) \
  begin \
    n_tests++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("mismatch %s expected %0h seen %0h", n, e, a); \
    end \
  end
module tb_top;
  logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, power_fail_input_n, standby_pin, osc_clock_pin, compare_update;
  logic        osc_fail_event, interrupt_output_pin_n, multi_function_output, irq;
  logic        hour_mode_12, clock_run, single_supply, time_save_enable, test_mode;
  logic [5:0]  s_axi_awaddr, s_axi_araddr, rollover_event, counter_equal, compare_enable;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, leap_count;
  int          failures, n_tests;
  localparam logic [3:0] MSR = `RTC_IDX_MAIN_STATUS;
  localparam logic [3:0] APE = `RTC_IDX_ALARM_PF_EN;

  rtc_intc_top #(.ADDR_W(6)) DUT (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .power_fail_input_n, .standby_pin, .osc_clock_pin, .rollover_event, .counter_equal,
    .compare_update, .osc_fail_event, .interrupt_output_pin_n, .multi_function_output, .irq,
    .compare_enable, .leap_count, .hour_mode_12, .clock_run, .single_supply,
    .time_save_enable, .test_mode
  );
  rtc_host_bfm host (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  always #2.5 clk = ~clk;

  task automatic wrr(input logic [3:0] i, input logic [7:0] d);
    logic [1:0] r;
    host.wr({i, 2'b00}, d, r);
    `CHK("bresp", rtc_intc_pkg::RTC_OKAY, r)
  endtask : wrr

  task automatic rdc(input string n, input logic [3:0] i, input logic [7:0] e,
                     input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    host.rd({i, 2'b00}, d, r);
    `CHK(n, {24'h000000, e}, d)
    `CHK(n, er, r)
  endtask : rdc

  // Sync stages, output and summary registers
  task automatic settle;
    repeat (5) @(posedge clk);
    #1;
  endtask : settle

  task automatic pulse_cmp(input logic [5:0] eq);
    @(posedge clk);
    counter_equal <= eq;
    compare_update <= 1'b1;
    @(posedge clk);
    compare_update <= 1'b0;
    settle();
  endtask : pulse_cmp

  task automatic stby(input logic v);
    @(posedge clk);
    standby_pin <= v;
    settle();
  endtask : stby

  task automatic t_alarm;
    wrr(MSR, 8'h40);
    rdc("msr_b1", MSR, 8'h40);
    wrr(APE, 8'h03);
    `CHK("cmp_en", 6'h03, compare_enable)
    pulse_cmp(6'h01);
    rdc("msr_nomatch", MSR, 8'h40);
    pulse_cmp(6'h03);
    rdc("msr_alarm", MSR, 8'h48);
    `CHK("interrupt_output_pin_masked", 1'b1, interrupt_output_pin_n)
    wrr(APE, 8'h43);
    settle();
    `CHK("interrupt_output_pin_alarm", 1'b0, interrupt_output_pin_n)
    rdc("msr_sum", MSR, 8'h49);
    wrr(MSR, 8'h48);
    rdc("msr_clr", MSR, 8'h40);
    `CHK("interrupt_output_pin_clr", 1'b1, interrupt_output_pin_n)
    wrr(APE, 8'h40);
    pulse_cmp(6'h3F);
    rdc("msr_alloff", MSR, 8'h40);
  endtask : t_alarm

  task automatic t_power_fail_input;
    wrr(APE, 8'h00);
    @(posedge clk);
    power_fail_input_n <= 1'b0;
    settle();
    rdc("msr_pf", MSR, 8'h42);
    `CHK("interrupt_output_pin_pf_off", 1'b1, interrupt_output_pin_n)
    wrr(APE, 8'h80);
    settle();
    `CHK("interrupt_output_pin_pf", 1'b0, interrupt_output_pin_n)
    `CHK("mfo_pf", 1'b1, multi_function_output)
    wrr(MSR, 8'h42);
    rdc("msr_pf_w", MSR, 8'h43);
    @(posedge clk);
    power_fail_input_n <= 1'b1;
    settle();
    rdc("msr_pf_end", MSR, 8'h40);
    wrr(APE, 8'h00);
  endtask : t_power_fail_input

  task automatic t_periodic;
    wrr(`RTC_IDX_PERIODIC, 8'h20);
    wrr(MSR, 8'h00);
    @(posedge clk);
    rollover_event <= 6'h21;
    @(posedge clk);
    rollover_event <= 6'h00;
    settle();
    `CHK("interrupt_output_pin_per", 1'b0, interrupt_output_pin_n)
    rdc("msr_per", MSR, 8'h05);
    rdc("pfr_set", `RTC_IDX_PERIODIC, 8'h61);
    rdc("pfr_clr", `RTC_IDX_PERIODIC, 8'h40);
    wrr(`RTC_IDX_PERIODIC, 8'hBF);
    rdc("pfr_ro", `RTC_IDX_PERIODIC, 8'hC0);
    `CHK("test", 1'b1, test_mode)
    wrr(MSR, 8'h05);
    rdc("msr_per_clr", MSR, 8'h00);
  endtask : t_periodic

  task automatic t_mode_standby;
    wrr(MSR, 8'h40);
    wrr(`RTC_IDX_REAL_TIME_MODE, 8'h1D);
    rdc("rtm", `RTC_IDX_REAL_TIME_MODE, 8'h1D);
    `CHK("mode", 5'h0F, {leap_count, hour_mode_12, clock_run, single_supply})
    wrr(MSR, 8'h00);
    rdc("pfr_osc_ok", `RTC_IDX_PERIODIC, 8'h80);
    wrr(`RTC_IDX_PERIODIC, 8'h00);
    `CHK("batt", 1'b0, single_supply)
    wrr(MSR, 8'h40);
    wrr(`RTC_IDX_PERIODIC, 8'h3F);
    wrr(APE, 8'hC0);
    stby(1'b1);
    rdc("apie_keep", APE, 8'hC0);
    stby(1'b0);
    wrr(`RTC_IDX_REAL_TIME_MODE, 8'h09);
    stby(1'b1);
    rdc("apie_clr", APE, 8'h00);
    rdc("pie_clr", `RTC_IDX_PERIODIC, 8'h00);
    stby(1'b0);
  endtask : t_mode_standby

  task automatic t_irq;
    logic [1:0] r;
    wrr(`RTC_IDX_IRQ_CLEAR, 8'h0F);
    rdc("ist_clr", `RTC_IDX_IRQ_STATUS, 8'h00);
    wrr(`RTC_IDX_IRQ_ENABLE, 8'h01);
    @(posedge clk);
    osc_fail_event <= 1'b1;
    @(posedge clk);
    osc_fail_event <= 1'b0;
    settle();
    `CHK("irq_masked", 1'b0, irq)
    `CHK("osc_fail", 2'h1, {clock_run, single_supply})
    rdc("ist_osc", `RTC_IDX_IRQ_STATUS, 8'h08);
    wrr(`RTC_IDX_IRQ_ENABLE, 8'h08);
    settle();
    `CHK("irq_on", 1'b1, irq)
    host.stall = 3;
    wrr(`RTC_IDX_IRQ_CLEAR, 8'h08);
    settle();
    `CHK("irq_off", 1'b0, irq)
    rdc("icl_read", `RTC_IDX_IRQ_CLEAR, 8'h00);
    rdc("unmapped", 4'hF, 8'h00, rtc_intc_pkg::RTC_SLVERR);
    host.wr(6'h3C, 8'hFF, r);
    `CHK("unmapped_wr", rtc_intc_pkg::RTC_SLVERR, r)
    host.stall = 0;
  endtask : t_irq

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    #100000;
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    end_sim();
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    power_fail_input_n = 1'b1;
    standby_pin = 1'b0;
    osc_clock_pin = 1'b0;
    rollover_event = 6'h00;
    counter_equal = 6'h00;
    compare_update = 1'b0;
    osc_fail_event = 1'b0;
    failures = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc("msr_rst", MSR, 8'h00);
    rdc("pfr_rst", `RTC_IDX_PERIODIC, 8'h40);
    t_alarm();
    t_power_fail_input();
    t_periodic();
    t_mode_standby();
    t_irq();
    end_sim();
  end
endmodule : tb_top
